// ### core/acl_pkg.sv
// Purpose: shared constants for the access control list rule evaluator
// Assumes: AHB-Lite register bus, 32-bit words, 10 MHz hclk
// Notes: every offset is a byte address; all tables reset to zero
package acl_pkg;
  ////////////////////////////////////////////////////////////////////////
  // table sizes
  localparam int NUM_ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam int COUNT_W = 11;
  ////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [11:0] MR_BASE = 12'h000;  // matching rules, 16 bytes each
  localparam logic [11:0] AR_BASE = 12'h100;  // action rules, one word each
  localparam logic [11:0] PE_BASE = 12'h140;  // processing entries, one word each
  localparam logic [11:0] CNT_BASE = 12'h1c0; // live counter values, read only
  localparam logic [11:0] STATUS_ADDR = 12'h180; // last evaluation result
  localparam logic [11:0] CMODE_ADDR = 12'h184;  // rules in counter mode
  localparam logic [1:0] MR_WORD_CTRL = 2'h0;
  localparam logic [1:0] MR_WORD_A = 2'h1;
  localparam logic [1:0] MR_WORD_B = 2'h2;
  ////////////////////////////////////////////////////////////////////////
  // matching rule control word fields
  localparam int MR_LAYER_LSB = 0;    // match_layer_select [1:0]
  localparam int MR_OPTION_LSB = 2;   // match_option_select [3:2]
  localparam int MR_SD_BIT = 4;       // 0 destination, 1 source
  localparam int MR_POLARITY_BIT = 5; // match_polarity
  localparam int MR_CTRL_W = 6;
  ////////////////////////////////////////////////////////////////////////
  // action rule word fields; bits [10:0] double as the count value
  localparam int AR_MAP_LSB = 0;      // forward_map_mode [1:0]
  localparam int AR_REMARK_LSB = 2;   // remarked_priority_value [4:2]
  localparam int AR_REMARK_EN_BIT = 5; // remark_enable_bit
  localparam int AR_PRIO_LSB = 6;     // priority value [8:6]
  localparam int AR_PMODE_LSB = 9;    // priority_mode_field [10:9]
  localparam int AR_TIME_UNIT_BIT = 11; // count_time_unit
  localparam int AR_ALGO_BIT = 12;    // counter_algorithm_select
  localparam int AR_W = 13;
  ////////////////////////////////////////////////////////////////////////
  // processing entry word fields
  localparam int PE_MASK_LSB = 0;     // condition_group_mask [15:0]
  localparam int PE_PTR_LSB = 16;     // action_pointer [19:16]
  localparam int PE_W = 20;
  ////////////////////////////////////////////////////////////////////////
  // encodings
  localparam logic [1:0] LAYER_OFF = 2'h0;
  localparam logic [1:0] LAYER_L2 = 2'h1;
  localparam logic [1:0] LAYER_L3 = 2'h2;
  localparam logic [1:0] LAYER_L4 = 2'h3;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  ////////////////////////////////////////////////////////////////////////
  // time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_US_NS = 1000;
  localparam int US_PER_MS = 1000;
  localparam int US_CYCLES = TICK_US_NS / CLK_PERIOD_NS;
  localparam logic [9:0] US_CNT_LAST = 10'(US_CYCLES - 1);
  localparam logic [9:0] MS_CNT_LAST = 10'(US_PER_MS - 1);
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ### core/acl_rule_evaluator.sv
// Purpose: per-port access control list evaluation on parsed ingress headers
// Assumes: header fields come from logic on hclk, one packet per pkt_valid pulse
// Notes: result appears one cycle after pkt_valid; tables are AHB-Lite registers
`timescale 1ns/1ns
module acl_rule_evaluator (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pkt_valid,
  input wire logic [47:0] pkt_dst_mac,
  input wire logic [47:0] pkt_src_mac,
  input wire logic [15:0] pkt_ethertype,
  input wire logic pkt_is_ipv4,
  input wire logic [31:0] pkt_src_ip,
  input wire logic [31:0] pkt_dst_ip,
  input wire logic [7:0] pkt_ip_proto,
  input wire logic [15:0] pkt_src_port,
  input wire logic [15:0] pkt_dst_port,
  input wire logic [31:0] pkt_tcp_seq,
  output logic act_valid,
  output logic act_hit,
  output logic [3:0] act_index,
  output logic [1:0] act_priority_mode,
  output logic [2:0] act_priority,
  output logic act_remark_en,
  output logic [2:0] act_remark_pri,
  output logic [1:0] act_map_mode,
  output logic [15:0] count_event
);
  localparam int N = acl_pkg::NUM_ENTRIES;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [acl_pkg::MR_CTRL_W-1:0] mr_ctrl_ff [N];  // matching rule control
  logic [31:0] mr_a_ff [N];                      // mac low / address / value
  logic [31:0] mr_b_ff [N];                      // mac high+type / mask / dest
  logic [acl_pkg::AR_W-1:0] ar_ff [N];           // action rules
  logic [acl_pkg::PE_W-1:0] pe_ff [N];           // processing entries
  logic [acl_pkg::COUNT_W-1:0] cnt_ff [N];       // per-rule counters
  logic [acl_pkg::MR_CTRL_W-1:0] nxt_mr_ctrl [N];
  logic [31:0] nxt_mr_a [N];
  logic [31:0] nxt_mr_b [N];
  logic [acl_pkg::AR_W-1:0] nxt_ar [N];
  logic [acl_pkg::PE_W-1:0] nxt_pe [N];
  logic [acl_pkg::COUNT_W-1:0] nxt_cnt [N];
  logic [9:0] us_cnt_ff, nxt_us_cnt;   // cycles within a microsecond
  logic [9:0] ms_cnt_ff, nxt_ms_cnt;   // microseconds within a millisecond
  logic dp_wr_ff, nxt_dp_wr;           // write data phase pending
  logic [11:0] dp_addr_ff, nxt_dp_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic act_valid_ff, nxt_act_valid;
  logic act_hit_ff, nxt_act_hit;
  logic [3:0] act_index_ff, nxt_act_index;
  logic [10:0] act_fields_ff, nxt_act_fields;
  logic [15:0] event_ff, nxt_event;
  // combinational evaluation results
  logic [15:0] match_res;   // per matching rule, usable by entries
  logic [15:0] count_hit;   // per counter-mode rule, qualifying packet
  logic [15:0] count_mode;  // rule is layer two option zero
  logic [15:0] act_vec;     // actions requested by matching entries
  logic us_tick, ms_tick;

  ////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write: {kind, index, word}
  // kind 1 rule, 2 action, 3 entry, 4 status, 5 counter mode, 6 counter
  function automatic logic [8:0] decode(input logic [11:0] a);
    logic [8:0] d;
    d = 9'h000;
    if (a < acl_pkg::AR_BASE) begin
      if (a[3:2] != 2'h3) begin
        d = {3'h1, a[7:4], a[3:2]};
      end
    end else if (a < acl_pkg::PE_BASE) begin
      d = {3'h2, a[5:2], 2'h0};
    end else if (a < acl_pkg::STATUS_ADDR) begin
      d = {3'h3, a[5:2], 2'h0};
    end else if (a == acl_pkg::STATUS_ADDR) begin
      d = {3'h4, 6'h00};
    end else if (a == acl_pkg::CMODE_ADDR) begin
      d = {3'h5, 6'h00};
    end else if (a >= acl_pkg::CNT_BASE && a < 12'(acl_pkg::CNT_BASE + 12'h040)) begin
      d = {3'h6, a[5:2], 2'h0};
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // matching rule evaluation
  always_comb begin
    logic [5:0] c;
    logic [1:0] layer, opt;
    logic sd, pol, same, ok;
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] port;
    c = '0;
    layer = '0;
    opt = '0;
    sd = 1'b0;
    pol = 1'b0;
    same = 1'b0;
    ok = 1'b0;
    mac = '0;
    ip = '0;
    port = '0;
    match_res = '0;
    count_hit = '0;
    count_mode = '0;
    for (int i = 0; i < N; i++) begin
      c = mr_ctrl_ff[i];
      layer = c[acl_pkg::MR_LAYER_LSB +: 2];
      opt = c[acl_pkg::MR_OPTION_LSB +: 2];
      sd = c[acl_pkg::MR_SD_BIT];
      pol = c[acl_pkg::MR_POLARITY_BIT];
      mac = sd ? pkt_src_mac : pkt_dst_mac;
      ip = sd ? pkt_src_ip : pkt_dst_ip;
      port = sd ? pkt_src_port : pkt_dst_port;
      same = 1'b0;
      ok = 1'b0;
      unique case (layer)
        acl_pkg::LAYER_OFF: begin
          ok = 1'b0;
        end
        acl_pkg::LAYER_L2: begin
          // mac and type held across words a and b
          ok = 1'b1;
          unique case (opt)
            2'h1: same = (mac == {mr_b_ff[i][15:0], mr_a_ff[i]});
            2'h2: same = (pkt_ethertype == mr_b_ff[i][31:16]);
            default: same = (mac == {mr_b_ff[i][15:0], mr_a_ff[i]}) &&
                          (pkt_ethertype == mr_b_ff[i][31:16]);
          endcase
          if (opt == 2'h0) begin
            // counter rule feeds only its counter
            count_mode[i] = 1'b1;
            count_hit[i] = pkt_valid && (pol ? same : !same);
            ok = 1'b0;
          end
        end
        acl_pkg::LAYER_L3: begin
          ok = pkt_is_ipv4 && (opt == 2'h1 || opt == 2'h2);
          if (opt == 2'h1) begin
            same = (((ip ^ mr_a_ff[i]) & ~mr_b_ff[i]) == 32'h0000_0000);
          end else begin
            same = (pkt_src_ip == mr_a_ff[i]) && (pkt_dst_ip == mr_b_ff[i]);
          end
        end
        acl_pkg::LAYER_L4: begin
          unique case (opt)
            2'h0: begin
              ok = pkt_is_ipv4;
              same = (pkt_ip_proto == mr_a_ff[i][7:0]);
            end
            2'h1: begin
              ok = pkt_is_ipv4 && (pkt_ip_proto == acl_pkg::PROTO_TCP);
              same = (port == mr_a_ff[i][15:0]);
            end
            2'h2: begin
              ok = pkt_is_ipv4 && (pkt_ip_proto == acl_pkg::PROTO_UDP);
              same = (port == mr_a_ff[i][15:0]);
            end
            default: begin
              ok = pkt_is_ipv4 && (pkt_ip_proto == acl_pkg::PROTO_TCP);
              same = (pkt_tcp_seq == mr_a_ff[i]);
            end
          endcase
        end
      endcase
      match_res[i] = ok && (pol ? same : !same);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // processing entries and action selection
  always_comb begin
    logic [15:0] m;
    logic [3:0] p;
    m = '0;
    p = '0;
    act_vec = '0;
    for (int j = 0; j < N; j++) begin
      m = pe_ff[j][acl_pkg::PE_MASK_LSB +: 16];
      p = pe_ff[j][acl_pkg::PE_PTR_LSB +: 4];
      // an empty mask selects nothing and never fires
      if (m != 16'h0000 && (m & match_res) == m) begin
        act_vec[p] = 1'b1;
      end
    end
    act_vec = act_vec & ~count_mode;
    nxt_act_hit = pkt_valid && (act_vec != 16'h0000);
    nxt_act_index = act_index_ff;
    nxt_act_fields = act_fields_ff;
    nxt_act_valid = pkt_valid;
    if (pkt_valid) begin
      nxt_act_index = 4'h0;
      nxt_act_fields = '0;
      // scan from the top so the lowest pointer wins
      for (int k = N - 1; k >= 0; k--) begin
        if (act_vec[k]) begin
          nxt_act_index = 4'(k);
          nxt_act_fields = ar_ff[k][10:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base and counters
  always_comb begin
    logic [10:0] cval;
    logic tick;
    cval = '0;
    tick = 1'b0;
    us_tick = (us_cnt_ff == acl_pkg::US_CNT_LAST);
    ms_tick = us_tick && (ms_cnt_ff == acl_pkg::MS_CNT_LAST);
    nxt_us_cnt = us_tick ? 10'h000 : 10'(us_cnt_ff + 10'h001);
    nxt_ms_cnt = ms_cnt_ff;
    if (us_tick) begin
      nxt_ms_cnt = ms_tick ? 10'h000 : 10'(ms_cnt_ff + 10'h001);
    end
    nxt_event = '0;
    for (int i = 0; i < N; i++) begin
      cval = ar_ff[i][10:0];
      tick = ar_ff[i][acl_pkg::AR_TIME_UNIT_BIT] ? ms_tick : us_tick;
      nxt_cnt[i] = cnt_ff[i];
      if (!count_mode[i]) begin
        // idle rules stay preloaded for when counting starts
        nxt_cnt[i] = ar_ff[i][acl_pkg::AR_ALGO_BIT] ? 11'h000 : cval;
      end else if (ar_ff[i][acl_pkg::AR_ALGO_BIT]) begin
        if (count_hit[i]) begin
          if (11'(cnt_ff[i] + 11'h001) == cval) begin
            nxt_event[i] = 1'b1;
            nxt_cnt[i] = 11'h000;
          end else begin
            nxt_cnt[i] = 11'(cnt_ff[i] + 11'h001);
          end
        end
      end else if (count_hit[i]) begin
        nxt_cnt[i] = cval;
      end else if (tick && cnt_ff[i] != 11'h000) begin
        if (cnt_ff[i] == 11'h001) begin
          nxt_event[i] = 1'b1;
          nxt_cnt[i] = cval;
        end else begin
          nxt_cnt[i] = 11'(cnt_ff[i] - 11'h001);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: address phase capture, read data, table writes
  always_comb begin
    logic [8:0] rd;
    logic [8:0] wd;
    rd = decode(haddr[11:0]);
    wd = decode(dp_addr_ff);
    nxt_dp_wr = hsel && htrans[1] && hready && hwrite;
    nxt_dp_addr = (hsel && htrans[1] && hready) ? haddr[11:0] : dp_addr_ff;
    nxt_hrdata = hrdata_ff;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (rd[8:6])
        3'h1: begin
          unique case (rd[1:0])
            acl_pkg::MR_WORD_CTRL: nxt_hrdata = 32'(mr_ctrl_ff[rd[5:2]]);
            acl_pkg::MR_WORD_A: nxt_hrdata = mr_a_ff[rd[5:2]];
            default: nxt_hrdata = mr_b_ff[rd[5:2]];
          endcase
        end
        3'h2: nxt_hrdata = 32'(ar_ff[rd[5:2]]);
        3'h3: nxt_hrdata = 32'(pe_ff[rd[5:2]]);
        3'h4: nxt_hrdata = {27'h0, act_hit_ff, act_index_ff};
        3'h5: nxt_hrdata = {16'h0000, count_mode};
        3'h6: nxt_hrdata = 32'(cnt_ff[rd[5:2]]);
        default: nxt_hrdata = acl_pkg::RESET_WORD;  // unmapped reads zero
      endcase
    end
    nxt_mr_ctrl = mr_ctrl_ff;
    nxt_mr_a = mr_a_ff;
    nxt_mr_b = mr_b_ff;
    nxt_ar = ar_ff;
    nxt_pe = pe_ff;
    if (dp_wr_ff) begin
      unique case (wd[8:6])
        3'h1: begin
          unique case (wd[1:0])
            acl_pkg::MR_WORD_CTRL: nxt_mr_ctrl[wd[5:2]] = hwdata[acl_pkg::MR_CTRL_W-1:0];
            acl_pkg::MR_WORD_A: nxt_mr_a[wd[5:2]] = hwdata;
            default: nxt_mr_b[wd[5:2]] = hwdata;
          endcase
        end
        3'h2: nxt_ar[wd[5:2]] = hwdata[acl_pkg::AR_W-1:0];
        3'h3: nxt_pe[wd[5:2]] = hwdata[acl_pkg::PE_W-1:0];
        default: ;  // read-only and unmapped writes are dropped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; ce low freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N; i++) begin
        mr_ctrl_ff[i] <= '0;
        mr_a_ff[i] <= acl_pkg::RESET_WORD;
        mr_b_ff[i] <= acl_pkg::RESET_WORD;
        ar_ff[i] <= '0;
        pe_ff[i] <= '0;
        cnt_ff[i] <= '0;
      end
      us_cnt_ff <= 10'h000;
      ms_cnt_ff <= 10'h000;
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 12'h000;
      hrdata_ff <= acl_pkg::RESET_WORD;
      act_valid_ff <= 1'b0;
      act_hit_ff <= 1'b0;
      act_index_ff <= 4'h0;
      act_fields_ff <= 11'h000;
      event_ff <= 16'h0000;
    end else if (ce) begin
      mr_ctrl_ff <= nxt_mr_ctrl;
      mr_a_ff <= nxt_mr_a;
      mr_b_ff <= nxt_mr_b;
      ar_ff <= nxt_ar;
      pe_ff <= nxt_pe;
      cnt_ff <= nxt_cnt;
      us_cnt_ff <= nxt_us_cnt;
      ms_cnt_ff <= nxt_ms_cnt;
      dp_wr_ff <= nxt_dp_wr;
      dp_addr_ff <= nxt_dp_addr;
      hrdata_ff <= nxt_hrdata;
      act_valid_ff <= nxt_act_valid;
      act_hit_ff <= nxt_act_hit;
      act_index_ff <= nxt_act_index;
      act_fields_ff <= nxt_act_fields;
      event_ff <= nxt_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout = ce;  // stalls the bus while frozen
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign act_valid = act_valid_ff;
  assign act_hit = act_hit_ff;
  assign act_index = act_index_ff;
  assign act_priority_mode = act_fields_ff[acl_pkg::AR_PMODE_LSB +: 2];
  assign act_priority = act_fields_ff[acl_pkg::AR_PRIO_LSB +: 3];
  assign act_remark_en = act_fields_ff[acl_pkg::AR_REMARK_EN_BIT];
  assign act_remark_pri = act_fields_ff[acl_pkg::AR_REMARK_LSB +: 3];
  assign act_map_mode = act_fields_ff[acl_pkg::AR_MAP_LSB +: 2];
  assign count_event = event_ff;
endmodule

// ### sim/acl_hdr_source.sv
// Purpose: model of the ingress header parser feeding the evaluator
// Assumes: one header per go cycle, same clock as the evaluator
// Notes: idle fields show the inverse of the last header, never stale values
`timescale 1ns/1ns
module acl_hdr_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [248:0] hdr,
  output logic pkt_valid,
  output logic [47:0] pkt_dst_mac,
  output logic [47:0] pkt_src_mac,
  output logic [15:0] pkt_ethertype,
  output logic pkt_is_ipv4,
  output logic [31:0] pkt_src_ip,
  output logic [31:0] pkt_dst_ip,
  output logic [7:0] pkt_ip_proto,
  output logic [15:0] pkt_src_port,
  output logic [15:0] pkt_dst_port,
  output logic [31:0] pkt_tcp_seq
);
  logic [248:0] last_ff; // last header sent
  logic [248:0] nxt_last;
  logic [248:0] cur;
  // remember each header as it goes out
  always_comb nxt_last = go ? hdr : last_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) last_ff <= '0;
    else last_ff <= nxt_last;
  end
  // fields are only meaningful with pkt_valid; otherwise show the inverse
  always_comb begin
    pkt_valid = go;
    cur = go ? hdr : ~last_ff;
  end
  assign {pkt_dst_mac, pkt_src_mac, pkt_ethertype, pkt_is_ipv4, pkt_src_ip, pkt_dst_ip, pkt_ip_proto,
    pkt_src_port, pkt_dst_port, pkt_tcp_seq} = cur;
endmodule

// ### sim/acl_rule_evaluator_checker.sv
// Purpose: port-level assertions for the access control list evaluator
// Assumes: one clock domain, hresetn asynchronous active low
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ns
module acl_rule_evaluator_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic pkt_valid,
  input wire logic act_valid,
  input wire logic act_hit,
  input wire logic [3:0] act_index,
  input wire logic [1:0] act_priority_mode,
  input wire logic [2:0] act_priority,
  input wire logic act_remark_en,
  input wire logic [2:0] act_remark_pri,
  input wire logic [1:0] act_map_mode,
  input wire logic [15:0] count_event
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  // read address phase taken by the slave
  logic rd_take;
  assign rd_take = hsel && htrans[1] && hready && ce && !hwrite;
  // a packet taken, then two idle cycles
  sequence s_pkt;
    pkt_valid && ce;
  endsequence
  sequence s_quiet;
    (ce && !pkt_valid) [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (s_pkt |=> act_valid)
    else $error("no result after packet");
  chk_no_spur: assert property (ce && !pkt_valid |=> !act_valid)
    else $error("result without packet");
  chk_miss_zero: assert property (act_valid && !act_hit |->
    {act_index, act_priority_mode, act_priority, act_remark_en, act_remark_pri, act_map_mode} == 15'h0)
    else $error("miss carries action fields");
  chk_fields_hold: assert property (act_valid ##1 s_quiet |->
    $stable(act_index) && $stable(act_priority) && $stable(act_map_mode))
    else $error("action fields moved without packet");
  chk_ce_freeze: assert property (!ce |=> $stable(act_valid) && $stable(count_event))
    else $error("state moved with ce low");
  chk_ready_ce: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_rdata_stands: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without read");
endmodule
bind acl_rule_evaluator acl_rule_evaluator_checker u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .pkt_valid(pkt_valid), .act_valid(act_valid), .act_hit(act_hit), .act_index(act_index),
  .act_priority_mode(act_priority_mode), .act_priority(act_priority), .act_remark_en(act_remark_en),
  .act_remark_pri(act_remark_pri), .act_map_mode(act_map_mode), .count_event(count_event));

// ### sim/acl_rule_evaluator_tb_top.sv
// Purpose: self-checking bench for the access control list evaluator
// Assumes: 10 MHz hclk, tables programmed over AHB-Lite
// Notes: each scenario is a task that checks its own results
`timescale 1ns/1ns
module acl_rule_evaluator_tb_top;
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, go = 0, v4 = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, sip = 32'hc0a8_0001, dip = 32'h0a00_0002, seq = 32'h1357_9bdf;
  logic [31:0] p_sip, p_dip, p_seq;
  logic [1:0] htrans = 0, act_priority_mode, act_map_mode;
  logic [2:0] hsize = 3'h2, act_priority, act_remark_pri;
  logic hreadyout, hresp, pkt_valid, p_v4, act_valid, act_hit, act_remark_en;
  logic [47:0] dmac = 48'h0011_2233_4455, smac = 48'h00aa_bbcc_ddee, p_dmac, p_smac;
  logic [15:0] typ = 16'h88b5, sport = 16'h1234, dport = 16'h0050, p_typ, p_sport, p_dport, count_event, ev;
  logic [7:0] proto = 8'h06, p_proto;
  logic [3:0] act_index;
  int err_total = 0, compares = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  always #50 hclk = ~hclk;
  acl_hdr_source u_src (.hclk(hclk), .hresetn(hresetn), .go(go),
    .hdr({dmac, smac, typ, v4, sip, dip, proto, sport, dport, seq}), .pkt_valid(pkt_valid),
    .pkt_dst_mac(p_dmac), .pkt_src_mac(p_smac), .pkt_ethertype(p_typ), .pkt_is_ipv4(p_v4), .pkt_src_ip(p_sip),
    .pkt_dst_ip(p_dip), .pkt_ip_proto(p_proto), .pkt_src_port(p_sport), .pkt_dst_port(p_dport), .pkt_tcp_seq(p_seq));
  acl_rule_evaluator DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pkt_valid(pkt_valid), .pkt_dst_mac(p_dmac), .pkt_src_mac(p_smac), .pkt_ethertype(p_typ),
    .pkt_is_ipv4(p_v4), .pkt_src_ip(p_sip), .pkt_dst_ip(p_dip), .pkt_ip_proto(p_proto), .pkt_src_port(p_sport),
    .pkt_dst_port(p_dport), .pkt_tcp_seq(p_seq), .act_valid(act_valid), .act_hit(act_hit), .act_index(act_index),
    .act_priority_mode(act_priority_mode), .act_priority(act_priority), .act_remark_en(act_remark_en),
    .act_remark_pri(act_remark_pri), .act_map_mode(act_map_mode), .count_event(count_event));
  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single AHB-Lite transfer; waits for hready in both phases
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1, a, d, r);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(0, a, 0, r);
    chk(r, e);
  endtask
  // table writers: matching rule, action rule, processing entry
  task mr(input int i, input logic [31:0] c, input logic [31:0] a, input logic [31:0] b);
    wr(acl_pkg::MR_BASE + 12'(16 * i), c);
    wr(acl_pkg::MR_BASE + 12'(16 * i + 4), a);
    wr(acl_pkg::MR_BASE + 12'(16 * i + 8), b);
  endtask
  task ar(input int i, input logic [31:0] v);
    wr(acl_pkg::AR_BASE + 12'(4 * i), v);
  endtask
  task pe(input int i, input logic [15:0] m, input logic [3:0] p);
    wr(acl_pkg::PE_BASE + 12'(4 * i), {12'h0, p, m});
  endtask
  // one packet; result is looked at in its one valid cycle
  task send;
    @(posedge hclk);
    go <= 1;
    @(posedge hclk);
    go <= 0;
    #1;
    ev = count_event;
  endtask
  task expa(input logic h, input logic [3:0] i, input logic [10:0] f);
    send;
    chk({act_valid, act_hit, act_index, act_priority_mode, act_priority, act_remark_en, act_remark_pri,
      act_map_mode}, {15'h0, 1'b1, h, i, f});
  endtask
  task wait_ev(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (count_event[3] !== 1'b1 && n < 25000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdc(acl_pkg::MR_BASE, acl_pkg::RESET_WORD);
    wr(acl_pkg::MR_BASE, 32'hffff_ffff);
    rdc(acl_pkg::MR_BASE, 32'h3f);
    wr(12'h800, 32'h1);
    rdc(12'h800, 32'h0);
    wr(acl_pkg::STATUS_ADDR, 32'h1f);
    rdc(acl_pkg::STATUS_ADDR, 32'h0);
    wr(acl_pkg::MR_BASE, 32'h0);
    $display("test regs done");
  endtask
  task t_l2;
    ar(2, 32'h5a5);
    pe(0, 16'h1, 4'h2);
    for (int o = 1; o < 4; o++) begin
      mr(0, 32'h21 | (o << 2), dmac[31:0], {typ, dmac[47:32]});
      expa(1, 4'h2, 11'h5a5);
      dmac[0] = ~dmac[0];
      expa(o == 2, (o == 2) ? 4'h2 : 4'h0, (o == 2) ? 11'h5a5 : 11'h0);
      dmac[0] = ~dmac[0];
    end
    mr(0, 32'h35, smac[31:0], {typ, smac[47:32]});
    expa(1, 4'h2, 11'h5a5);
    mr(0, 32'h15, smac[31:0], {typ, smac[47:32]});
    expa(0, 4'h0, 11'h0);
    mr(0, 32'h05, smac[31:0], {typ, smac[47:32]});
    expa(1, 4'h2, 11'h5a5);
    $display("test l2 done");
  endtask
  task t_prio;
    ar(4, 32'h0e1);
    mr(0, 32'h25, dmac[31:0], {typ, dmac[47:32]});
    mr(1, 32'h29, 32'h0, {typ, 16'h0});
    mr(2, 32'h25, ~dmac[31:0], {typ, dmac[47:32]});
    pe(0, 16'h3, 4'h7);
    pe(1, 16'h5, 4'h1);
    pe(2, 16'h2, 4'h4);
    expa(1, 4'h4, 11'h0e1);
    pe(2, 16'h4, 4'h4);
    pe(3, 16'h1, 4'h4);
    expa(1, 4'h4, 11'h0e1);
    pe(3, 16'h4, 4'h4);
    expa(1, 4'h7, 11'h0);
    rdc(acl_pkg::STATUS_ADDR, 32'h07);
    for (int i = 0; i < 4; i++) pe(i, 16'h0, 4'h0);
    mr(1, 0, 0, 0);
    mr(2, 0, 0, 0);
    $display("test prio done");
  endtask
  task t_l34;
    logic [31:0] tc [11];
    logic [31:0] ta [11];
    logic [31:0] tb [11];
    logic th [11];
    tc = '{32'h36, 32'h36, 32'h2a, 32'h22, 32'h2e, 32'h2c, 32'h23, 32'h27, 32'h37, 32'h2b, 32'h2f};
    ta = '{sip ^ 32'h5a, sip ^ 32'h5a, sip, sip, sip, 0, {24'h0, proto}, {16'h0, dport}, {16'h0, sport},
      {16'h0, dport}, seq};
    tb = '{32'hff, 32'h0, dip, dip, dip, 0, 0, 0, 0, 0, 0};
    th = '{1, 0, 1, 0, 0, 0, 1, 1, 1, 0, 1};
    pe(0, 16'h1, 4'h2);
    for (int k = 0; k < 11; k++) begin
      mr(0, tc[k], ta[k], tb[k]);
      expa(th[k], th[k] ? 4'h2 : 4'h0, th[k] ? 11'h5a5 : 11'h0);
    end
    $display("test l34 done");
  endtask
  task t_count;
    int n;
    logic seen;
    ar(3, 32'h1003);
    mr(3, 32'h21, dmac[31:0], {typ, dmac[47:32]});
    pe(0, 16'h1, 4'h3);
    rdc(acl_pkg::CMODE_ADDR, 32'h8);
    ev = 0;
    for (int k = 0; k < 2100 && ev[3] !== 1'b1; k++) send;
    for (int k = 1; k < 4; k++) begin
      expa(0, 4'h0, 11'h0);
      chk(ev, (k == 3) ? 16'h8 : 16'h0);
    end
    rdc(acl_pkg::CNT_BASE + 12'h00c, 32'h0);
    ar(3, 32'h0005);
    send;
    seen = 0;
    repeat (30) begin
      @(posedge hclk);
      #1;
      seen |= count_event[3];
    end
    chk(seen, 0);
    send;
    wait_ev(n);
    chk(n >= 40 && n <= 52, 1);
    ar(3, 32'h0802);
    send;
    wait_ev(n);
    chk(n > 9990 && n <= 20010, 1);
    $display("test count done");
  endtask
  task t_ce;
    @(posedge hclk);
    ce <= 0;
    repeat (3) @(posedge hclk);
    #1;
    chk(hreadyout, 0);
    @(posedge hclk);
    ce <= 1;
    $display("test ce done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    t_regs;
    t_l2;
    t_prio;
    t_l34;
    t_count;
    t_ce;
    print_verdict;
  end
endmodule
